// ---- dqm_client_model.sv ----
// client node model: sends slots, gaps and management octets on its own octet clock
`timescale 1ns/1ps

module dqm_client_model (
  input wire logic run,
  input wire logic mute,
  input wire logic go,
  output logic busy,
  output logic slot_clock_in,
  output logic [7:0] slot_data_in,
  output dqm_pkg::dqm_otype_t slot_octet_type,
  output logic octet_validity,
  output logic note_tog,
  output logic [7:0] note_byte,
  output logic [7:0] m1_sent,
  output logic [7:0] m2_sent
);
  import dqm_pkg::*;
  logic [31:0] lfsr_r;
  logic seen;

  // galois shift register step for random octets
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    lfsr_step = {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : lfsr_step

  // one octet: lines change at the falling octet clock, 160 ns period
  task automatic send(input logic [7:0] d, input dqm_otype_t t, input logic v, input logic n);
    slot_clock_in = 1'b0;
    slot_data_in = d;
    slot_octet_type = t;
    octet_validity = v;
    if (n && !mute) begin
      note_byte = d;
      note_tog = ~note_tog;
    end
    #80;
    slot_clock_in = 1'b1;
    #80;
  endtask : send

  // on each fresh trigger while running: slot of 53 octets, management pair once, 8 invalid gap octets
  initial begin
    lfsr_r = 32'h00008b66;
    slot_clock_in = 1'b0;
    slot_data_in = 8'h00;
    slot_octet_type = DQM_T_DATA;
    octet_validity = 1'b0;
    note_tog = 1'b0;
    note_byte = 8'h00;
    m1_sent = 8'h00;
    m2_sent = 8'h00;
    busy = 1'b0;
    seen = 1'b0;
    forever begin
      if (go === seen) begin
        // clock stands still; data keeps moving so no stale octet looks held
        slot_data_in = ~slot_data_in;
        octet_validity = 1'b0;
        #20;
      end else begin
        // a trigger seen while stopped is dropped, so no slot starts off the grid
        seen = go;
        if (run) begin
        busy = 1'b1;
        for (int i = 0; i < 53; i++) begin
          lfsr_r = lfsr_step(lfsr_r);
          if (i == 0) send({1'b1, lfsr_r[6:0]}, DQM_T_SLOT, 1'b1, 1'b1);
          else send(lfsr_r[7:0], DQM_T_DATA, 1'b1, 1'b1);
        end
        if (m1_sent === 8'h00) begin
          m1_sent = {1'b1, lfsr_r[14:8]};
          m2_sent = {1'b1, lfsr_r[22:16]};
          send(m1_sent, DQM_T_M1, 1'b1, 1'b0);
          send(m2_sent, DQM_T_M2, 1'b1, 1'b0);
        end
        for (int i = 0; i < 8; i++) send(~slot_data_in, DQM_T_DATA, 1'b0, 1'b0);
        busy = 1'b0;
        end
      end
    end
  end
endmodule : dqm_client_model

// ---- dqm_fifo.sv ----
// octet fifo between the slot capture and the container mapper
`timescale 1ns/1ps
`include "dqm_regs.svh"

module dqm_fifo #(
  parameter int WIDTH = `DQM_FIFO_W,
  parameter int DEPTH = `DQM_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  // depth must be a power of two, pointers wrap naturally
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // honest flags from the fill count
  assign in_ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_r];

  // pointers and fill count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wr_r <= AW'(wr_r + 1'b1);
      if (pop) rd_r <= AW'(rd_r + 1'b1);
      cnt_r <= (AW+1)'(cnt_r + (AW+1)'(push) - (AW+1)'(pop));
    end
  end

  // storage array
  always_ff @(posedge clk) begin
    if (push) mem_r[wr_r] <= in_data;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_FIFO_FULL: assert property (!in_ready |-> cnt_r == (AW+1)'(DEPTH))
    else $error("fifo refuses while not full");
  AST_FIFO_CNT: assert property ((push && !pop) |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("fifo count did not follow a push");
endmodule : dqm_fifo

// ---- dqm_mapper.sv ----
// slot stream to container-4 source mapper, top level
`timescale 1ns/1ps
`include "dqm_regs.svh"

// Functional notes
// RQ1: slots fill payload row by row on octet bounds and may span frames.
// RQ2: client marks each slot's first octet and both management octets.
// RQ3: client marks every octet valid or invalid.
// RQ4: scrambler runs only on the 48 payload octets, else holds state.
// RQ5: scrambler is self-synchronous, output xor output 43 bits back.
// RQ6: header check field is xored with 01010101 before mapping.
// RQ7: a six-bit slot boundary field goes out once per frame.
// RQ8: link status code sits in bits 1 and 2 of the position byte.
// RQ9: status codes are 00 connected, 11 down, 01 up, 10 no head of bus.
// RQ10: bits 3 to 8 count octets from position byte to next slot start.
// RQ11: slot offset value always lies between 0 and 52.
// RQ12: payload label byte carries 0001 0100.
// RQ13: first management octet in F2, second in F3.
// RQ14: frame start output is generated locally, not from the client.
// RQ15: container outputs are driven only while activated.
// RQ16: client stream frequency stays within 4,6 ppm of nominal.
// RQ17: management octets are handled independently of slot octets.
// RQ18: invalid or missing input maps void slots of 53 zero octets.
// RQ19: remote link status is copied into the next frame's position byte.
module dqm_mapper (
  input wire logic clk,
  input wire logic rst,
  input wire logic slot_clock_in,
  input wire logic [7:0] slot_data_in,
  input wire dqm_pkg::dqm_otype_t slot_octet_type,
  input wire logic octet_validity,
  input wire logic client_signal_fail_in,
  input wire dqm_pkg::dqm_lss_t remote_link_status_in,
  input wire logic function_activate,
  output logic [7:0] container_data_out,
  output logic container_clock_out,
  output logic container_frame_start_out,
  output logic container_drive
);
  import dqm_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [`DQM_SYNC_W-1:0] async_in;
  logic [`DQM_SYNC_W-1:0] lvl_w;
  logic sl_clk;
  logic [7:0] sl_data;
  logic [1:0] sl_type_bits;
  logic sl_valid;
  logic sl_fail;
  logic [1:0] sl_lss;
  logic sl_act;

  // everything from the pins crosses in one bundle
  assign async_in = {function_activate, remote_link_status_in, client_signal_fail_in,
                     octet_validity, slot_octet_type, slot_data_in, slot_clock_in};

  // three stages per bit, a level counts once stages two and three agree
  for (genvar i = 0; i < `DQM_SYNC_W; i++) begin : g_sync
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        s1_r <= 1'b0;
        s2_r <= 1'b0;
        s3_r <= 1'b0;
        lvl_r <= 1'b0;
      end else begin
        s1_r <= async_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) lvl_r <= s3_r;
      end
    end
    assign lvl_w[i] = lvl_r;
  end

  // split the filtered bundle back into named levels
  assign {sl_act, sl_lss, sl_fail, sl_valid, sl_type_bits, sl_data, sl_clk} = lvl_w;

  // ----------------------------------------------------------------
  // octet capture on the slot clock rising edge
  // ----------------------------------------------------------------
  logic sl_clk_d_r;
  logic sl_edge;
  logic cap_valid_r;
  logic [`DQM_FIFO_W-1:0] cap_word_r;
  logic f_in_ready;
  logic f_valid;
  logic f_pop;
  logic [`DQM_FIFO_W-1:0] f_word;

  assign sl_edge = sl_clk & ~sl_clk_d_r;

  // edge detector on the filtered clock level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) sl_clk_d_r <= 1'b0;
    else sl_clk_d_r <= sl_clk;
  end

  // holding stage waits for fifo room; a failed client counts as invalid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cap_valid_r <= 1'b0;
      cap_word_r <= '0;
    end else if (sl_edge) begin
      cap_valid_r <= 1'b1;
      cap_word_r <= {sl_type_bits, sl_valid & ~sl_fail, sl_data}; // RQ2 RQ3
    end else if (f_in_ready) begin
      cap_valid_r <= 1'b0;
    end
  end

  dqm_fifo #(
    .WIDTH(`DQM_FIFO_W),
    .DEPTH(`DQM_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(cap_valid_r),
    .in_ready(f_in_ready),
    .in_data(cap_word_r),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_word)
  );

  // ----------------------------------------------------------------
  // octet timing and container frame position
  // ----------------------------------------------------------------
  logic [`DQM_DIV_W-1:0] div_r;
  logic [`DQM_DIV_W-1:0] div_nxt;
  logic oct_en;
  logic [3:0] row_r;
  logic [8:0] col_r;
  logic is_poh;
  logic oct_pay;
  logic frame_pos;

  // one octet per divider turn, clock output high in the second half
  assign oct_en = (div_r == `DQM_DIV_W'(`DQM_OCT_CYC - 1));
  assign div_nxt = oct_en ? '0 : `DQM_DIV_W'(div_r + 1'b1);
  assign is_poh = (col_r == `DQM_COL_POH);
  assign oct_pay = oct_en & ~is_poh;
  assign frame_pos = is_poh & (row_r == `DQM_ROW_J1);

  // divider
  always_ff @(posedge clk or posedge rst) begin
    if (rst) div_r <= '0;
    else div_r <= div_nxt;
  end

  // row and column of the octet being emitted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_r <= `DQM_ROW_J1;
      col_r <= `DQM_COL_POH;
    end else if (oct_en) begin
      if (col_r == `DQM_COLS - 1'b1) begin
        col_r <= `DQM_COL_POH;
        row_r <= (row_r == `DQM_ROWS - 1'b1) ? `DQM_ROW_J1 : 4'(row_r + 1'b1);
      end else begin
        col_r <= 9'(col_r + 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------
  // slot assembly from the fifo head
  // ----------------------------------------------------------------
  logic [1:0] h_type_bits;
  dqm_otype_t h_type;
  logic h_ok;
  logic [7:0] h_data;
  logic h_is_m1;
  logic h_is_m2;
  logic h_is_data;
  logic h_is_start;
  logic [5:0] slot_pos_r;
  dqm_src_t src_r;
  logic at_start;
  logic in_real;
  logic start_ok;
  logic pop_start;
  logic pop_data;
  logic pop_orphan;
  logic take;
  logic [7:0] raw;

  assign {h_type_bits, h_ok, h_data} = f_word;
  assign h_type = dqm_otype_t'(h_type_bits);
  assign h_is_m1 = f_valid & (h_type == DQM_T_M1);
  assign h_is_m2 = f_valid & (h_type == DQM_T_M2);
  assign h_is_data = f_valid & (h_type == DQM_T_DATA);
  assign h_is_start = f_valid & (h_type == DQM_T_SLOT);

  // a real slot starts only on a valid first octet at a slot boundary
  assign at_start = (slot_pos_r == '0);
  assign in_real = (src_r == DQM_SRC_REAL) & ~at_start;
  assign start_ok = h_is_start & h_ok;
  assign pop_start = oct_pay & at_start & h_is_start;
  assign pop_data = oct_pay & in_real & h_is_data;
  // stray body octets outside a real slot are dropped at once
  assign pop_orphan = h_is_data & ~in_real;
  // management octets leave the fifo whenever they reach its head
  assign f_pop = h_is_m1 | h_is_m2 | pop_start | pop_data | pop_orphan; // RQ17
  // missing or invalid octets become zero, so a void slot is all zeros
  assign take = (pop_start | pop_data) & h_ok;
  assign raw = take ? h_data : `DQM_VOID; // RQ18

  // slot octet position, runs only on payload octets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_pos_r <= '0;
      src_r <= DQM_SRC_VOID;
    end else if (oct_pay) begin
      slot_pos_r <= (slot_pos_r == `DQM_SLOT_LAST) ? '0 : 6'(slot_pos_r + 1'b1); // RQ1
      if (at_start) src_r <= start_ok ? DQM_SRC_REAL : DQM_SRC_VOID; // RQ18
    end
  end

  // ----------------------------------------------------------------
  // header check pattern and payload scrambling
  // ----------------------------------------------------------------
  logic is_hcs;
  logic is_body;
  logic [7:0] scr_out;
  logic [7:0] proc;

  assign is_hcs = (slot_pos_r == `DQM_HCS_POS);
  assign is_body = (slot_pos_r >= `DQM_HDR_LEN);
  assign proc = is_hcs ? (raw ^ `DQM_HCS_MASK) : (is_body ? scr_out : raw); // RQ6

  dqm_scrambler u_scr (
    .clk(clk),
    .rst(rst),
    .en(oct_pay & is_body),
    .data_in(raw),
    .data_out(scr_out)
  );

  // ----------------------------------------------------------------
  // path overhead bytes
  // ----------------------------------------------------------------
  logic [7:0] m1_r;
  logic [7:0] m2_r;
  dqm_lss_t lss_r;
  logic [5:0] offset;
  logic [7:0] h4;
  logic [7:0] poh;
  logic [7:0] oct_val;

  // octets still to come before the next slot boundary
  assign offset = at_start ? '0 : 6'(`DQM_SLOT_LEN - slot_pos_r); // RQ10 RQ11
  assign h4 = {lss_r, offset}; // RQ7 RQ8 RQ9
  assign poh = (row_r == `DQM_ROW_C2) ? `DQM_C2_CODE : // RQ12
               (row_r == `DQM_ROW_F2) ? m1_r : // RQ13
               (row_r == `DQM_ROW_H4) ? h4 :
               (row_r == `DQM_ROW_F3) ? m2_r : `DQM_POH_FILL; // RQ13
  assign oct_val = is_poh ? poh : proc;

  // management octets are sent once, then zero; a new arrival wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      m1_r <= `DQM_VOID;
      m2_r <= `DQM_VOID;
    end else begin
      if (h_is_m1) m1_r <= h_ok ? h_data : `DQM_VOID; // RQ13
      else if (oct_en & is_poh & (row_r == `DQM_ROW_F2)) m1_r <= `DQM_VOID;
      if (h_is_m2) m2_r <= h_ok ? h_data : `DQM_VOID; // RQ13
      else if (oct_en & is_poh & (row_r == `DQM_ROW_F3)) m2_r <= `DQM_VOID;
    end
  end

  // link status sampled at frame start, sent in that frame's position byte
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lss_r <= DQM_LSS_DOWN;
    else if (oct_en & frame_pos) lss_r <= dqm_lss_t'(sl_lss); // RQ19
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [7:0] data_out_r;
  logic clk_out_r;
  logic fs_r;
  logic drive_r;

  // outputs stay quiet unless activated; fs is local, never the client's
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_out_r <= '0;
      fs_r <= 1'b0;
      drive_r <= 1'b0;
    end else if (oct_en) begin
      data_out_r <= sl_act ? oct_val : '0; // RQ15
      fs_r <= sl_act & frame_pos; // RQ14
      drive_r <= sl_act; // RQ15
    end
  end

  // container clock, rising in mid octet, only inside an octet that is driven
  always_ff @(posedge clk or posedge rst) begin
    if (rst) clk_out_r <= 1'b0;
    else clk_out_r <= drive_r & (div_nxt >= `DQM_DIV_W'(`DQM_OCT_CYC / 2)); // RQ15
  end

  assign container_data_out = data_out_r;
  assign container_clock_out = clk_out_r;
  assign container_frame_start_out = fs_r;
  assign container_drive = drive_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_h4_strobe;
    oct_en && is_poh && (row_r == `DQM_ROW_H4) && sl_act;
  endsequence

  sequence s_frame_strobe;
    oct_en && frame_pos && sl_act;
  endsequence

  AST_SLOT_WRAP: assert property ((oct_pay && slot_pos_r == `DQM_SLOT_LAST) |=> at_start) // RQ1
    else $error("slot position did not wrap after 53 octets");
  AST_OFFSET_RANGE: assert property (s_h4_strobe |=> container_data_out[5:0] <= `DQM_SLOT_LAST) // RQ11
    else $error("slot offset out of range");
  AST_OFFSET_ZERO: assert property ((s_h4_strobe and at_start) |=> container_data_out[5:0] == '0) // RQ10
    else $error("offset not zero at slot boundary");
  AST_LSS_BITS: assert property (s_h4_strobe |=> container_data_out[7:6] == lss_r) // RQ8
    else $error("link status bits wrong in position byte");
  AST_LSS_COPY: assert property (s_frame_strobe |=> lss_r == $past(sl_lss)) // RQ19
    else $error("link status not taken at frame start");
  AST_C2: assert property ((oct_en && is_poh && row_r == `DQM_ROW_C2 && sl_act)
                           |=> container_data_out == `DQM_C2_CODE) // RQ12
    else $error("payload label wrong");
  AST_HCS: assert property ((oct_pay && is_hcs && sl_act)
                            |=> container_data_out == ($past(raw) ^ `DQM_HCS_MASK)) // RQ6
    else $error("header check field not masked");
  AST_VOID: assert property ((oct_pay && src_r == DQM_SRC_VOID && !at_start) |-> raw == `DQM_VOID) // RQ18
    else $error("void slot carried data");
  AST_FS: assert property (s_frame_strobe |=> container_frame_start_out[*8] ##1
                           !container_frame_start_out) // RQ14
    else $error("frame start not a single octet at frame origin");
  AST_IDLE: assert property ($fell(sl_act) |-> ##[1:8] (!container_drive && !container_clock_out)) // RQ15
    else $error("outputs still driven after deactivation");
  AST_M1: assert property ((h_is_m1 && h_ok) |=> m1_r == $past(h_data)) // RQ13
    else $error("first management octet not stored");
endmodule : dqm_mapper

// ---- dqm_mapper_tb.sv ----
// self-checking bench for the slot to container mapper
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end

module dqm_mapper_tb;
  import dqm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic act = 1'b0;
  logic fail = 1'b0;
  logic run = 1'b0;
  logic go = 1'b0;
  logic busy;
  dqm_lss_t link_status_code = DQM_LSS_CONNECTED;
  dqm_lss_t exp_lss = DQM_LSS_CONNECTED;
  dqm_otype_t stype;
  logic sclk, valid, ntog, cclk, cfs, cdrv, have_fs, sync, seen1, seen2;
  logic [7:0] sdata, nbyte, m1, m2, cdata, d, e;
  logic [3:0] row;
  logic [8:0] col;
  logic [5:0] pos;
  logic [42:0] hist;
  logic [7:0] slot[53];
  logic [7:0] exp_q[$];
  int n_fail = 0;
  int total_checks = 0;
  int gap = 0;
  int n_h4 = 0;

  always #10 clk = ~clk;

  dqm_client_model cli (.run(run), .mute(fail), .go(go), .busy(busy),
    .slot_clock_in(sclk), .slot_data_in(sdata),
    .slot_octet_type(stype), .octet_validity(valid), .note_tog(ntog), .note_byte(nbyte),
    .m1_sent(m1), .m2_sent(m2));

  dqm_mapper uut (.clk(clk), .rst(rst), .slot_clock_in(sclk), .slot_data_in(sdata),
    .slot_octet_type(stype), .octet_validity(valid), .client_signal_fail_in(fail),
    .remote_link_status_in(link_status_code), .function_activate(act), .container_data_out(cdata),
    .container_clock_out(cclk), .container_frame_start_out(cfs), .container_drive(cdrv));

  // -------------------------------------------------------------
  // expectations and output watcher
  // -------------------------------------------------------------
  // every slot octet the client sends unmuted is noted for the watcher; management and gap octets are not
  // the start-up settle of the toggle is not an octet; the byte is read once it has settled
  always @(ntog) if (!rst) #1 exp_q.push_back(nbyte);

  // overhead column checks
  task automatic poh();
    case (row)
      4'h2: `CHK("c2", 8'h14, cdata)
      4'h4: begin
        if (cdata !== 8'h00) `CHK("f2", m1, cdata)
        if (cdata === m1 && m1 !== 8'h00) seen1 = 1'b1;
      end
      4'h6: begin
        if (cdata !== 8'h00) `CHK("f3", m2, cdata)
        if (cdata === m2 && m2 !== 8'h00) seen2 = 1'b1;
      end
      4'h5: begin
        `CHK("lss", exp_lss, cdata[7:6])
        `CHK("offset range", 1'b1, cdata[5:0] <= 6'h34)
        if (sync) `CHK("offset", (pos == 6'h00) ? 6'h00 : 6'h35 - pos, cdata[5:0])
        else pos = (cdata[5:0] == 6'h00) ? 6'h00 : 6'h35 - cdata[5:0];
        sync = 1'b1;
        n_h4++;
      end
      default: `CHK("poh fill", 8'h00, cdata)
    endcase
  endtask : poh

  // payload: undo scrambling from the output history, compare whole slots
  task automatic payload();
    d = cdata;
    if (pos == 6'h04) d = cdata ^ 8'h55;
    if (pos > 6'h04) begin
      for (int i = 7; i >= 0; i--) begin
        d[i] = cdata[i] ^ hist[42];
        hist = {hist[41:0], cdata[i]};
      end
    end
    slot[pos] = d;
    // seven octets before a boundary, ask the idle client for a slot so it lands on the grid
    if (pos == 6'h2e && busy === 1'b0) go = ~go;
    pos++;
    if (pos == 6'h35) begin
      pos = 6'h00;
      for (int i = 0; i < 53; i++) begin
        if (slot[0] === 8'h00) `CHK("void", 8'h00, slot[i])
        else begin
          e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
          `CHK("slot", e, slot[i])
        end
      end
      slot = '{default: 8'h00};
    end
  endtask : payload

  // octet watcher on the container clock
  always @(posedge cclk) begin
    `CHK("drive", 1'b1, cdrv)
    gap++;
    col++;
    if (col == 9'h105) begin
      col = 9'h000;
      row++;
    end
    if (cfs === 1'b1) begin
      if (have_fs) `CHK("frame len", 32'h0000092d, gap)
      have_fs = 1'b1;
      gap = 0;
      col = 9'h000;
      row = 4'h0;
      exp_lss = link_status_code;
      link_status_code <= #10 dqm_lss_t'(link_status_code + 2'h1);
    end
    if (have_fs && col == 9'h000) poh();
    else if (sync) payload();
  end

  // -------------------------------------------------------------
  // sequence
  // -------------------------------------------------------------
  task automatic quiet(input int n);
    repeat (n) begin
      @(negedge clk);
      `CHK("idle", 11'h000, {cdata, cclk, cfs, cdrv})
    end
  endtask : quiet

  task automatic wait_h4(input int k);
    for (int i = 0; i < 40000 && n_h4 < k; i++) @(negedge clk);
  endtask : wait_h4

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  // main flow: idle, live slots, failed client, deactivation
  initial begin
    have_fs = 1'b0;
    sync = 1'b0;
    seen1 = 1'b0;
    seen2 = 1'b0;
    row = 4'h0;
    col = 9'h000;
    pos = 6'h00;
    hist = '0;
    slot = '{default: 8'h00};
    repeat (6) @(negedge clk);
    rst = 1'b0;
    quiet(100);
    $display("test inactive done");
    act = 1'b1;
    wait_h4(1);
    run = 1'b1;
    repeat (21000) @(negedge clk);
    run = 1'b0;
    repeat (1000) @(negedge clk);
    $display("test slots done");
    fail = 1'b1;
    run = 1'b1;
    repeat (6000) @(negedge clk);
    run = 1'b0;
    repeat (1000) @(negedge clk);
    fail = 1'b0;
    wait_h4(4);
    `CHK("drained", 0, exp_q.size())
    `CHK("m1 seen", 1'b1, seen1)
    `CHK("m2 seen", 1'b1, seen2)
    $display("test void done");
    act = 1'b0;
    repeat (20) @(negedge clk);
    quiet(100);
    $display("test deactivate done");
    close_out();
  end

  // watchdog against a hang
  initial begin
    #1900000;
    n_fail++;
    close_out();
  end
endmodule : dqm_mapper_tb

// ---- dqm_pkg.sv ----
// types shared by the slot to container mapper
package dqm_pkg;
  // octet type marker driven by the client with every octet
  typedef enum logic [1:0] {
    DQM_T_DATA = 2'h0,
    DQM_T_SLOT = 2'h1,
    DQM_T_M1 = 2'h2,
    DQM_T_M2 = 2'h3
  } dqm_otype_t;

  // link status codes carried in the position byte
  typedef enum logic [1:0] {
    DQM_LSS_CONNECTED = 2'h0,
    DQM_LSS_UP = 2'h1,
    DQM_LSS_HOB_INCAP = 2'h2,
    DQM_LSS_DOWN = 2'h3
  } dqm_lss_t;

  // source of the slot being mapped, one-hot
  typedef enum logic [1:0] {
    DQM_SRC_VOID = 2'b01,
    DQM_SRC_REAL = 2'b10
  } dqm_src_t;
endpackage : dqm_pkg

// ---- dqm_regs.svh ----
// timing, framing and code constants for the slot to container mapper
`ifndef DQM_REGS_SVH
`define DQM_REGS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DQM_CLK_MHZ 50
`define DQM_OCT_NS 160
`define DQM_OCT_CYC ((`DQM_OCT_NS * `DQM_CLK_MHZ) / 1000)
`define DQM_DIV_W 4

// ----------------------------------------------------------------
// container framing
// ----------------------------------------------------------------
`define DQM_ROWS 4'h9
`define DQM_COLS 9'h105
`define DQM_ROW_J1 4'h0
`define DQM_ROW_C2 4'h2
`define DQM_ROW_F2 4'h4
`define DQM_ROW_H4 4'h5
`define DQM_ROW_F3 4'h6
`define DQM_COL_POH 9'h000
`define DQM_POH_FILL 8'h00
`define DQM_C2_CODE 8'h14

// ----------------------------------------------------------------
// slot layout
// ----------------------------------------------------------------
`define DQM_SLOT_LEN 6'h35
`define DQM_SLOT_LAST 6'h34
`define DQM_HCS_POS 6'h04
`define DQM_HDR_LEN 6'h05
`define DQM_HCS_MASK 8'h55
`define DQM_VOID 8'h00
`define DQM_SCR_LEN 43

// ----------------------------------------------------------------
// input path
// ----------------------------------------------------------------
`define DQM_SYNC_W 16
`define DQM_FIFO_W 11
`define DQM_FIFO_DEPTH 8

`endif

// ---- dqm_scrambler.sv ----
// self-synchronous x^43+1 payload scrambler, eight bits per enable
`timescale 1ns/1ps
`include "dqm_regs.svh"

module dqm_scrambler (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out
);
  logic [`DQM_SCR_LEN-1:0] sr_r;
  logic [`DQM_SCR_LEN-1:0] sr_nxt;

  // msb goes first; each bit meets the output bit 43 places back
  always_comb begin
    sr_nxt = sr_r;
    data_out = '0;
    for (int i = 7; i >= 0; i--) begin
      data_out[i] = data_in[i] ^ sr_nxt[`DQM_SCR_LEN-1]; // RQ5
      sr_nxt = {sr_nxt[`DQM_SCR_LEN-2:0], data_out[i]};
    end
  end

  // state advances only on payload octets
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sr_r <= '0;
    end else if (en) begin
      sr_r <= sr_nxt; // RQ4
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  AST_SCR_HOLD: assert property (!en |=> $stable(sr_r)) // RQ4
    else $error("scrambler state moved outside payload");
  AST_SCR_FEED: assert property (en |=> sr_r[7:0] == $past(data_out)) // RQ5
    else $error("scrambler did not feed back its output");
endmodule : dqm_scrambler
